// file: hw/i2cfe_defines.vh
`ifndef I2CFE_DEFINES_VH
`define I2CFE_DEFINES_VH
// Fixed slave address and framing constants
`define I2CFE_SLAVE_ADDR      7'h2F
`define I2CFE_WIPER_RESET     7'h3F
`define I2CFE_BIT_LAST        4'h7
`define I2CFE_BIT_ACK         4'h8
// Glitch filter: spikes up to 50 ns rejected at 5 ns clock
`define I2CFE_SPIKE_NS        50
`define I2CFE_CLK_NS          5
`define I2CFE_FILT_CYC        ((`I2CFE_SPIKE_NS + `I2CFE_CLK_NS - 1) / `I2CFE_CLK_NS)
`define I2CFE_FILT_W          4
`endif

// file: hw/i2cfe_filter.v
`default_nettype none
`include "i2cfe_defines.vh"

// Three-stage synchroniser followed by a stability filter
module i2cfe_filter (
   // Clock and reset
   input  wire       clk_i,
   input  wire       rst_b_i,
   // Raw pin and clean level
   input  wire       pin_i,
   output reg        level_o
);

   reg                     s1_reg;
   reg                     s2_reg;
   reg                     s3_reg;
   reg [`I2CFE_FILT_W-1:0] cnt_reg;

   // Idle bus is high, so reset to released level
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s1_reg  <= 1'b1;
         s2_reg  <= 1'b1;
         s3_reg  <= 1'b1;
         cnt_reg <= {`I2CFE_FILT_W{1'b0}};
         level_o <= 1'b1;
      end else begin
         s1_reg <= pin_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         // New level must hold for the whole filter window
         if (s2_reg != s3_reg || s3_reg == level_o) begin // RQ15
            cnt_reg <= {`I2CFE_FILT_W{1'b0}};
         end else if (cnt_reg == `I2CFE_FILT_CYC - 1) begin
            cnt_reg <= {`I2CFE_FILT_W{1'b0}};
            level_o <= s3_reg; // RQ15
         end else begin
            cnt_reg <= cnt_reg + 1'b1;
         end
      end
   end

endmodule // i2cfe_filter
`default_nettype wire

// file: hw/i2cfe_front_end.v
`default_nettype none
`include "i2cfe_defines.vh"

// Functional notes
// RQ1 - Slave only; clock line is never driven by this block.
// RQ2 - Works at 100 and 400 kb/s; sampling far faster than bus.
// RQ3 - Data falling while clock high starts a new transfer.
// RQ4 - Transmitter changes data only while clock low, stable while high.
// RQ5 - Matching address byte acknowledged by pulling data low on ninth clock.
// RQ6 - Non-matching address left unacknowledged; block drops out of transfer.
// RQ7 - After error, new start returns command state machine to idle start.
// RQ8 - Bus collision: no acknowledge, interface resets; collision at start ignored.
// RQ9 - Repeated start restarts framing without an intervening stop.
// RQ10 - Repeated start collision: data low at clock rise, or clock falls first. Only clock falling with data high after a restart is flagged.
// RQ11 - Data rising while clock high ends the transfer.
// RQ12 - On stop, interface state resets and waits for next start.
// RQ13 - Never stretches the clock; read data ready without waits.
// RQ14 - Malformed or interrupted transfers abort, wiper value untouched.
// RQ15 - Clock and data inputs glitch filtered before use.
// RQ16 - Lines only pulled low or released, never driven high.
// RQ17 - Idle after stop, active after start.
// RQ18 - Fixed address 0101111; eighth bit selects read or write.
// RQ19 - After invalid command, ignore bus until start and matching address.
// RQ20 - Lines synchronised, filtered, edges detected in local clock domain.
// RQ21 - Data pull-down changes only while clock low; released after ninth fall.
module i2cfe_front_end (
   // Clock and reset
   input  wire       clk_i,
   input  wire       rst_b_i,
   // Bus pins
   input  wire       scl_i,
   output reg        scl_o,
   output reg        scl_oe_o,
   input  wire       sda_i,
   output reg        sda_o,
   output reg        sda_oe_o,
   // Wiper and status
   output reg  [6:0] wiper_o,
   output reg        active_o,
   output reg        fast_rate_setting_o
);

   ////////////////////////////////////////////////////////////////////
   // Ignore state stays deaf and released until the next start
   localparam ST_IDLE  = 3'h0;
   localparam ST_ADDR  = 3'h1;
   localparam ST_WDATA = 3'h2;
   localparam ST_RDATA = 3'h3;
   localparam ST_IGN   = 3'h4;

   wire       scl_f;
   wire       sda_f;
   reg        scl_d_reg;
   reg        sda_d_reg;
   reg  [2:0] state_reg;
   reg  [3:0] bit_reg;
   reg  [7:0] shift_reg;
   reg        ack_phase_reg;
   reg        rd_nack_reg;
   reg        rstart_reg;
   reg        drive_low_reg;

   // Filtering trades a few cycles of latency for spike immunity
   // Equal filter lengths on both lines keep the data-to-clock order of the pins
   i2cfe_filter u_scl_filt (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .pin_i   (scl_i),
      .level_o (scl_f)
   );
   i2cfe_filter u_sda_filt (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .pin_i   (sda_i),
      .level_o (sda_f)
   );

   ////////////////////////////////////////////////////////////////////
   // Edge and condition detection on clean levels
   wire scl_rise = scl_f & ~scl_d_reg;             // RQ20
   wire scl_fall = ~scl_f & scl_d_reg;             // RQ20
   wire start_c  = scl_f & scl_d_reg & sda_d_reg & ~sda_f; // RQ3
   wire stop_c   = scl_f & scl_d_reg & ~sda_d_reg & sda_f; // RQ11
   // A released read bit seen low at clock rise: another driver owns the line
   wire rd_lost  = scl_rise & (state_reg == ST_RDATA) & ~ack_phase_reg & ~drive_low_reg & ~sda_f; // RQ8
   // Clock falling with data high straight after a restart
   wire rs_lost  = rstart_reg & scl_fall & sda_f; // RQ10
   wire collide  = rd_lost | rs_lost;

   // Only the seven upper bits name the slave; the last one is the direction
   function addr_match;
      input [7:0] b;
      begin
         addr_match = (b[7:1] == `I2CFE_SLAVE_ADDR); // RQ18
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scl_d_reg           <= 1'b1;
         sda_d_reg           <= 1'b1;
         state_reg           <= ST_IDLE;
         bit_reg             <= 4'h0;
         shift_reg           <= 8'h00;
         ack_phase_reg       <= 1'b0;
         rd_nack_reg         <= 1'b0;
         rstart_reg          <= 1'b0;
         drive_low_reg       <= 1'b0;
         wiper_o             <= `I2CFE_WIPER_RESET;
         active_o            <= 1'b0;
         fast_rate_setting_o <= 1'b0;
         scl_o               <= 1'b0;
         scl_oe_o            <= 1'b0; // RQ1 RQ13
         sda_o               <= 1'b0;
         sda_oe_o            <= 1'b0;
      end else begin
         scl_d_reg <= scl_f;
         sda_d_reg <= sda_f;
         // Pin output is only ever low; enable carries the drive
         sda_o     <= 1'b0; // RQ16
         sda_oe_o  <= drive_low_reg;
         // Sampling runs far faster than either bus rate, so both are always served
         fast_rate_setting_o <= 1'b1; // RQ2
         if (start_c) begin
            // Start and repeated start both rearm the address phase
            rstart_reg    <= (state_reg != ST_IDLE); // RQ9
            state_reg     <= ST_ADDR; // RQ7 RQ19
            active_o      <= 1'b1; // RQ17
            bit_reg       <= 4'h0;
            ack_phase_reg <= 1'b0;
            drive_low_reg <= 1'b0; // RQ14
         end else if (stop_c) begin
            // A stop inside a byte abandons it; the wiper keeps its old value
            state_reg     <= ST_IDLE; // RQ12
            active_o      <= 1'b0; // RQ17
            rstart_reg    <= 1'b0;
            drive_low_reg <= 1'b0; // RQ14
         end else if (collide && state_reg != ST_IDLE) begin
            // Losing the line ends our part in the transfer until the next start
            state_reg     <= ST_IGN; // RQ8
            drive_low_reg <= 1'b0; // RQ8
            rstart_reg    <= 1'b0;
         end else begin
            if (scl_fall) begin
               rstart_reg <= 1'b0;
            end
            case (state_reg)
               ST_ADDR, ST_WDATA: begin
                  // Bits are counted at rises, so the fall that closes a start is not taken for a bit
                  if (scl_rise && !ack_phase_reg) begin
                     shift_reg <= {shift_reg[6:0], sda_f}; // RQ4
                     bit_reg   <= bit_reg + 4'h1;
                  end
                  if (scl_fall) begin
                     if (ack_phase_reg) begin
                        ack_phase_reg <= 1'b0;
                        drive_low_reg <= 1'b0; // RQ21
                        bit_reg       <= 4'h0;
                        if (state_reg == ST_ADDR) begin
                           state_reg <= shift_reg[0] ? ST_RDATA : ST_WDATA;
                           if (shift_reg[0]) begin
                              // Top bit of the read byte is always zero, so the pull-down stays on
                              drive_low_reg <= 1'b1; // RQ21
                              shift_reg     <= {1'b0, wiper_o};
                           end
                        end
                     end else if (bit_reg == `I2CFE_BIT_ACK) begin
                        ack_phase_reg <= 1'b1;
                        if (state_reg == ST_ADDR) begin
                           if (addr_match(shift_reg)) begin
                              drive_low_reg <= 1'b1; // RQ5
                           end else begin
                              state_reg <= ST_IGN; // RQ6
                           end
                        end else begin
                           // Byte complete: commit only now
                           wiper_o       <= shift_reg[6:0]; // RQ14
                           drive_low_reg <= 1'b1; // RQ5
                        end
                     end
                  end
               end
               ST_RDATA: begin
                  // The master's ninth bit decides whether another byte follows
                  if (scl_rise && ack_phase_reg) begin
                     rd_nack_reg <= sda_f;
                  end
                  if (scl_fall) begin
                     if (ack_phase_reg) begin
                        ack_phase_reg <= 1'b0;
                        bit_reg       <= 4'h0;
                        if (rd_nack_reg) begin
                           state_reg     <= ST_IGN; // RQ19
                           drive_low_reg <= 1'b0;
                        end else begin
                           // Every read byte is zero then the wiper; its top bit goes out now
                           shift_reg     <= {1'b0, wiper_o};
                           drive_low_reg <= 1'b1; // RQ21
                        end
                     end else if (bit_reg == `I2CFE_BIT_LAST) begin
                        ack_phase_reg <= 1'b1;
                        drive_low_reg <= 1'b0; // RQ21
                     end else begin
                        bit_reg       <= bit_reg + 4'h1;
                        drive_low_reg <= ~shift_reg[6]; // RQ4 RQ21
                        shift_reg     <= {shift_reg[6:0], 1'b0};
                     end
                  end
               end
               ST_IGN: begin
                  // Released whatever happens until a start rearms the address phase
                  drive_low_reg <= 1'b0; // RQ19
               end
               default: begin
                  drive_low_reg <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule // i2cfe_front_end
`default_nettype wire

// file: testbench/i2cfe_asserts.sv
`default_nettype none
module i2cfe_asserts (
   input wire logic       clk_i,
   input wire logic       rst_b_i,
   input wire logic       scl_i,
   input wire logic       scl_o,
   input wire logic       scl_oe_o,
   input wire logic       sda_i,
   input wire logic       sda_o,
   input wire logic       sda_oe_o,
   input wire logic [6:0] wiper_o,
   input wire logic       active_o,
   input wire logic       fast_rate_setting_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   property p_no_stretch; !scl_oe_o; endproperty
   a_no_stretch: assert property (p_no_stretch) else $error("clock line driven");
   property p_pull_only; sda_oe_o |-> !sda_o; endproperty
   a_pull_only: assert property (p_pull_only) else $error("data driven high");
   property p_oe_low_phase; $changed(sda_oe_o) |-> !scl_i; endproperty
   a_oe_low_phase: assert property (p_oe_low_phase) else $error("data pull-down moved while clock high");
   property p_oe_in_frame; sda_oe_o |-> active_o; endproperty
   a_oe_in_frame: assert property (p_oe_in_frame) else $error("data pulled outside a transfer");
   // Start must have data low both now and 8 cycles earlier
   property p_start_seen; $rose(active_o) |-> !sda_i && !$past(sda_i, 8); endproperty
   a_start_seen: assert property (p_start_seen) else $error("activity without a start");
   property p_stop_seen; $fell(active_o) |-> sda_i && scl_i; endproperty
   a_stop_seen: assert property (p_stop_seen) else $error("idle without a stop");
   property p_wiper_commit; $changed(wiper_o) |-> !scl_i && active_o; endproperty
   a_wiper_commit: assert property (p_wiper_commit) else $error("wiper moved outside a byte end");
   property p_wiper_ack; $changed(wiper_o) |-> ##[0:40] sda_oe_o; endproperty
   a_wiper_ack: assert property (p_wiper_ack) else $error("written byte not acknowledged");
   property p_fast; $past(rst_b_i) |-> fast_rate_setting_o; endproperty
   a_fast: assert property (p_fast) else $error("fast rate not offered");
   c_write: cover property ($changed(wiper_o));
   c_ack: cover property ($rose(sda_oe_o));
   c_stop: cover property ($fell(active_o));
endmodule // i2cfe_asserts
bind i2cfe_front_end i2cfe_asserts u_i2cfe_asserts (.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl_i), .scl_o(scl_o),
   .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wiper_o(wiper_o),
   .active_o(active_o), .fast_rate_setting_o(fast_rate_setting_o));
`default_nettype wire

// file: testbench/i2cfe_master.sv
`default_nettype none
// Bus master: only pulls lines low or lets them go
module i2cfe_master (
   input  wire logic clk_i,
   input  wire logic sda_i,
   output var  logic scl_low_o = 1'b0,
   output var  logic sda_low_o = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Levels held 12 cycles so they outlast the slave's spike filter
   task automatic step(input logic s, input logic d);
      tick(10);
      sda_low_o <= d;
      tick(10);
      scl_low_o <= s;
      tick(12);
   endtask
   task automatic start();
      step(1'b0, 1'b0);
      sda_low_o <= 1'b1;
      tick(12);
      scl_low_o <= 1'b1;
   endtask
   task automatic stop();
      step(1'b0, 1'b1);
      sda_low_o <= 1'b0;
      tick(12);
   endtask
   // Data moves in the low phase; sampled mid-cycle at the end of the high phase
   task automatic bit_io(input logic b, output logic s);
      step(1'b0, ~b);
      @(negedge clk_i) s = sda_i;
      @(posedge clk_i) scl_low_o <= 1'b1;
   endtask
   // Nine bits: byte then acknowledge slot, most significant first
   task automatic byte_io(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--) bit_io(d[i], q[i]);
   endtask
   task automatic glitch(input int n);
      sda_low_o <= 1'b1;
      tick(n);
      sda_low_o <= 1'b0;
   endtask
endmodule // i2cfe_master
`default_nettype wire

// file: testbench/test_i2c_slave_bus_front_end.sv
`default_nettype none
module test_i2c_slave_bus_front_end;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_i = 1'b0;
   logic       rst_b_i = 1'b0;
   wire logic  scl_low, sda_low, scl_oe_o, sda_oe_o, active_o, scl_w, sda_w;
   wire logic [6:0] wiper_o;
   int         n_mismatch = 0, tests_run = 0, cyc = 0, seed = 32'h0000_4124;
   logic [8:0] q;
   logic [7:0] a, d;
   logic [6:0] w = 7'h3F;
   // Open-drain wires with pull-ups
   assign scl_w = ~(scl_low | scl_oe_o);
   assign sda_w = ~(sda_low | sda_oe_o);
   i2cfe_front_end u_i2cfe_front_end (.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe_o),
      .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe_o), .wiper_o(wiper_o), .active_o(active_o), .fast_rate_setting_o());
   i2cfe_master u_i2cfe_master (.clk_i(clk_i), .sda_i(sda_w), .scl_low_o(scl_low), .sda_low_o(sda_low));
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   function automatic logic [7:0] exp_ack(input logic [7:0] c);
      return (c[7:1] == 7'h2F) ? 8'h00 : 8'h01;
   endfunction
   task automatic xfer(input logic [7:0] c, input logic [7:0] v);
      u_i2cfe_master.start();
      u_i2cfe_master.byte_io({c, 1'b1}, q);
      check("ack", {7'h00, q[0]}, exp_ack(c));
      u_i2cfe_master.byte_io({v, 1'b1}, q);
      check("data ack", {7'h00, q[0]}, exp_ack(c));
      if (exp_ack(c) == 8'h00) w = v[6:0];
      check("wiper", {1'b0, wiper_o}, {1'b0, w});
   endtask
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (30) @(posedge clk_i);
      u_i2cfe_master.glitch(5);
      repeat (20) @(negedge clk_i) check("glitch", {7'h00, active_o}, 8'h00);
      // General call first, then random foreign addresses
      for (int i = 0; i < 4; i++) begin
         a = (i == 0) ? 8'h00 : 8'($random(seed));
         if (a[7:1] == 7'h2F) a[7] = 1'b1;
         xfer(a, 8'h55);
      end
      // Aborts: stop after four data bits, restart after five
      for (int i = 4; i < 6; i++) begin
         u_i2cfe_master.start();
         u_i2cfe_master.byte_io({8'h5E, 1'b1}, q);
         repeat (i) u_i2cfe_master.bit_io(1'b0, q[0]);
         if (i == 4) u_i2cfe_master.stop();
         else u_i2cfe_master.start();
         check("abort", {1'b0, wiper_o}, {1'b0, w});
      end
      // Odd passes read back after a stop, even ones after a repeated start
      for (int i = 0; i < 6; i++) begin
         d = 8'($random(seed));
         xfer(8'h5E, d);
         if (i[0]) u_i2cfe_master.stop();
         u_i2cfe_master.start();
         u_i2cfe_master.byte_io({8'h5F, 1'b1}, q);
         check("rd ack", {7'h00, q[0]}, 8'h00);
         u_i2cfe_master.byte_io({8'hFF, 1'b0}, q);
         check("rd data", q[8:1], {1'b0, w});
         u_i2cfe_master.byte_io({8'hFF, 1'b1}, q);
         check("rd next", q[8:1], {1'b0, w});
         u_i2cfe_master.stop();
         repeat (20) @(posedge clk_i);
         check("idle", {7'h00, active_o}, 8'h00);
      end
      // Another driver pulls a released read bit low: the slave must let go
      xfer(8'h5E, 8'h2A);
      u_i2cfe_master.start();
      u_i2cfe_master.byte_io({8'h5F, 1'b1}, q);
      check("coll ack", {7'h00, q[0]}, 8'h00);
      u_i2cfe_master.byte_io({8'h00, 1'b0}, q);
      u_i2cfe_master.byte_io({8'hFF, 1'b1}, q);
      check("collide", q[8:1], 8'hFF);
      u_i2cfe_master.stop();
      give_verdict();
   end
endmodule // test_i2c_slave_bus_front_end
`default_nettype wire
